// ===== core/lhp_slave_port.sv
// device end: slave register port, reset, and bus pin configuration
// Operation
// - reset input or stop bit halts everything
// - reset clears ctl0 to stop, clears cfg
// - run bit resumes operation after stop
// - host rewrites config after every stop
// - chip select enters slave register access mode
// - pointer write, then register access cycle
// - pointer holds until rewritten
// - host stops device before touching regs 1-3
// - strobe requests, ready acknowledges
// - regs 1 and 2 acknowledge later
// - latch polarity bit sets latch enable level
// - role clear: byte masks plus bus request
// - byte-mask mode requests bus when needed
// - role set: byte select, chain grant, request
// - grant passes downstream when not requesting
// - requesting device keeps grant, output high
// - chain request asserted only if line high
// - swap bit swaps bytes on dma transfers
// - tx ring pointer: length code, aligned base
// - regs 1 and 2 hold init block address
// - host avoids select while device holds bus
`timescale 1ns/1ps
module lhp_slave_port
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // link to host
    lhp_link_if.dev          link,
    // master side requests from the dma engine
    input  wire logic        memNeed,
    input  wire logic        dmaAddrLsb,
    input  wire logic        dmaByte,
    input  wire logic        dmaUpper,
    input  wire logic [15:0] fifoWord,
    input  wire logic        latchPhase,
    // open-drain chain request pin
    input  wire logic        chainReqIn,
    output logic             chainReqOut,
    output logic             chainReqOe,
    // bus pins
    output logic [1:0]       byte_mask_n,
    output logic             busRequest,
    output logic             byteSel,
    output logic             chain_grant_out_n,
    output logic             addrLatch,
    output logic [15:0]      memWord,
    // status
    output logic             running,
    output logic [31:0]      initBlockAddr,
    output logic             slaveMode
);
    import lhp_pkg::*;

    typedef struct packed {
        lhp_state_t  state;
        logic [3:0]  count;
        logic [1:0]  ptr;
        logic [15:0] ctl0;
        logic [15:0] adrl;
        logic [15:0] adrh;
        logic [15:0] cfg;
        logic [15:0] devData;
        logic        reqHeld;
        logic        ownGrant;
    } lhp_dev_t;

    lhp_dev_t cur;
    lhp_dev_t next_cur;
    logic     isLong;
    logic     stopped;
    logic     roleCtl;
    logic     latchPolarity;
    logic     byteOrderSwap;

    assign roleCtl       = cur.cfg[LHP_BIT_ROLE];
    assign latchPolarity = cur.cfg[LHP_BIT_LATCH];
    assign byteOrderSwap = cur.cfg[LHP_BIT_SWAP];
    assign stopped       = cur.ctl0[LHP_BIT_STOP];
    assign isLong        = lhp_is_long(link.ptrSel, cur.ptr);

    // next state: slave access sequencing and register effects
    always_comb
    begin
        next_cur = cur;
        case (cur.state)
            LHP_IDLE:
            begin
                // chip select with strobe opens a slave access
                if (!link.chipSel_n && !link.data_strobe_n)
                begin
                    next_cur.state = LHP_WAIT;
                    next_cur.count = isLong ? LHP_LONG_CYC
                                            : LHP_SHORT_CYC;
                end
            end
            LHP_WAIT:
            begin
                if (cur.count > 4'h1)
                begin
                    next_cur.count = cur.count - 4'h1;
                end
                else
                begin
                    next_cur.state = LHP_ACK;
                    if (link.ptrSel)
                    begin
                        if (!link.readNotWrite)
                        begin
                            next_cur.ptr = link.hostData[1:0];
                        end
                        next_cur.devData = {14'h0000, cur.ptr};
                    end
                    else if (link.readNotWrite)
                    begin
                        case (cur.ptr)
                            LHP_SEL_CTL0: next_cur.devData = cur.ctl0;
                            LHP_SEL_ADRL: next_cur.devData = cur.adrl;
                            LHP_SEL_ADRH: next_cur.devData = cur.adrh;
                            default:      next_cur.devData = cur.cfg;
                        endcase
                    end
                    else
                    begin
                        case (cur.ptr)
                            LHP_SEL_CTL0:
                            begin
                                if (link.hostData[LHP_BIT_STOP])
                                begin
                                    // soft reset also clears config
                                    next_cur.ctl0 = LHP_CTL0_RST;
                                    next_cur.cfg  = LHP_CFG_RST;
                                    next_cur.reqHeld  = 1'b0;
                                    next_cur.ownGrant = 1'b0;
                                end
                                else if (link.hostData[LHP_BIT_RUN]
                                         || link.hostData[LHP_BIT_INIT])
                                begin
                                    next_cur.ctl0[LHP_BIT_STOP] = 1'b0;
                                    next_cur.ctl0[LHP_BIT_ON]   = 1'b1;
                                    next_cur.ctl0[LHP_BIT_RUN]  =
                                        link.hostData[LHP_BIT_RUN];
                                    next_cur.ctl0[LHP_BIT_INIT] =
                                        link.hostData[LHP_BIT_INIT];
                                end
                            end
                            // written only while stopped to be honoured
                            LHP_SEL_ADRL:
                                if (stopped) next_cur.adrl = link.hostData;
                            LHP_SEL_ADRH:
                                if (stopped) next_cur.adrh = link.hostData;
                            default:
                                if (stopped) next_cur.cfg = link.hostData;
                        endcase
                    end
                end
            end
            LHP_ACK:
            begin
                // ready holds until the strobe is withdrawn
                if (link.data_strobe_n)
                begin
                    next_cur.state = LHP_IDLE;
                end
            end
            default: next_cur.state = LHP_IDLE;
        endcase
        // bus request and daisy chain grant handling
        if (stopped)
        begin
            next_cur.reqHeld  = 1'b0;
            next_cur.ownGrant = 1'b0;
        end
        else if (!roleCtl)
        begin
            next_cur.reqHeld  = memNeed;
            next_cur.ownGrant = memNeed && link.bus_grant_in;
        end
        else
        begin
            // join the shared line only while nobody else pulls it
            if (memNeed && !cur.reqHeld && chainReqIn)
                next_cur.reqHeld = 1'b1;
            else if (!memNeed)
                next_cur.reqHeld = 1'b0;
            next_cur.ownGrant = cur.reqHeld && link.bus_grant_in;
        end
    end

    // single state register; async reset loads constants only
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur         <= '0;
            cur.state   <= LHP_IDLE;
            cur.ctl0    <= LHP_CTL0_RST;
            cur.cfg     <= LHP_CFG_RST;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // link outputs
    assign link.ready   = (cur.state == LHP_ACK);
    assign link.devData = cur.devData;

    // pin roles follow the configuration
    always_comb
    begin
        byte_mask_n       = 2'b11;
        busRequest        = 1'b0;
        byteSel           = 1'b0;
        chain_grant_out_n = 1'b1;
        chainReqOut       = 1'b0;
        chainReqOe        = 1'b0;
        if (!roleCtl)
        begin
            busRequest = cur.reqHeld;
            if (cur.ownGrant)
                byte_mask_n = dmaByte ? (dmaUpper ? 2'b01 : 2'b10) : 2'b00;
        end
        else
        begin
            byteSel    = dmaByte;
            chainReqOe = cur.reqHeld;
            // grant passes on unless we asked for it
            chain_grant_out_n = !(link.bus_grant_in && !cur.reqHeld);
        end
    end

    assign addrLatch     = latchPhase ^ !latchPolarity;
    assign memWord       = byteOrderSwap ? {fifoWord[7:0], fifoWord[15:8]}
                                         : fifoWord;
    assign running       = !stopped;
    assign initBlockAddr = {cur.adrh, cur.adrl};
    assign slaveMode     = !link.chipSel_n;
endmodule // lhp_slave_port

// ===== core/lhp_pkg.sv
// shared constants and types for the host slave port and its host end
package lhp_pkg;
    // register selection through the low pointer bits
    localparam logic [1:0] LHP_SEL_CTL0 = 2'h0;
    localparam logic [1:0] LHP_SEL_ADRL = 2'h1;
    localparam logic [1:0] LHP_SEL_ADRH = 2'h2;
    localparam logic [1:0] LHP_SEL_CFG  = 2'h3;
    // control register 0 bit positions
    localparam int LHP_BIT_STOP  = 2;
    localparam int LHP_BIT_RUN   = 1;
    localparam int LHP_BIT_INIT  = 0;
    localparam int LHP_BIT_ON    = 3;
    // configuration register 3 bit positions
    localparam int LHP_BIT_SWAP  = 2;
    localparam int LHP_BIT_LATCH = 1;
    localparam int LHP_BIT_ROLE  = 0;
    // reset values
    localparam logic [15:0] LHP_CTL0_RST = 16'h0004;
    localparam logic [15:0] LHP_CFG_RST  = 16'h0000;
    // acknowledge delays in clock cycles (50 ns each)
    localparam int LHP_SHORT_NS = 100;
    localparam int LHP_LONG_NS  = 300;
    localparam int LHP_CLK_NS   = 50;
    localparam logic [3:0] LHP_SHORT_CYC =
        4'((LHP_SHORT_NS + LHP_CLK_NS - 1) / LHP_CLK_NS);
    localparam logic [3:0] LHP_LONG_CYC =
        4'((LHP_LONG_NS + LHP_CLK_NS - 1) / LHP_CLK_NS);
    // transmit ring pointer layout
    localparam int LHP_TX_RING_LEN_CODE_MSB = 31;
    localparam int LHP_TX_RING_LEN_CODE_LSB = 29;
    localparam logic [2:0] LHP_RING_ALIGN = 3'h0;
    // apb map of the host end
    localparam logic [7:0] LHP_APB_CMD    = 8'h00;
    localparam logic [7:0] LHP_APB_WDATA  = 8'h04;
    localparam logic [7:0] LHP_APB_RDATA  = 8'h08;
    localparam logic [7:0] LHP_APB_STATUS = 8'h0C;
    localparam logic [7:0] LHP_APB_RING   = 8'h10;
    // slave port states
    typedef enum logic [1:0] {
        LHP_IDLE = 2'b00,
        LHP_WAIT = 2'b01,
        LHP_ACK  = 2'b10
    } lhp_state_t;
    // host end states
    typedef enum logic [1:0] {
        LHP_H_IDLE = 2'b00,
        LHP_H_STRB = 2'b01,
        LHP_H_DONE = 2'b10
    } lhp_hstate_t;
    // the registers whose delay class is long
    function automatic logic lhp_is_long(input logic isPtr,
                                         input logic [1:0] sel);
        return !isPtr && (sel == LHP_SEL_ADRL || sel == LHP_SEL_ADRH);
    endfunction
endpackage

// ===== core/lhp_link_if.sv
// link between the host end and the device slave port
`timescale 1ns/1ps
interface lhp_link_if;
    logic        chipSel_n;
    logic        data_strobe_n;
    logic        readNotWrite;
    logic        ptrSel;
    logic [15:0] hostData;
    logic [15:0] devData;
    logic        ready;
    logic        bus_grant_in;
    modport dev  (input chipSel_n, data_strobe_n, readNotWrite, ptrSel,
                  hostData, bus_grant_in, output devData, ready);
    modport host (output chipSel_n, data_strobe_n, readNotWrite, ptrSel,
                  hostData, input devData, ready, bus_grant_in);
endinterface

// ===== core/lhp_host_end.sv
// host end: apb-controlled initiator of single link cycles, one per command write accepted while idle with bus_grant_in low
`timescale 1ns/1ps
module lhp_host_end
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // link to device
    lhp_link_if.host         link,
    // ring pointer word for the init block
    output logic [31:0]      txRingPtr
);
    import lhp_pkg::*;

    typedef struct packed {
        lhp_hstate_t st;
        logic        rd;
        logic        ptrCyc;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        done;
        logic [2:0]  tx_ring_len_code;
        logic [20:0] tx_ring_base;
    } lhp_host_t;

    lhp_host_t cur;
    lhp_host_t next_cur;
    logic      wrAcc;

    assign wrAcc = psel && penable && pwrite;

    // next state: apb writes launch link cycles
    always_comb
    begin
        next_cur = cur;
        if (wrAcc && paddr == LHP_APB_WDATA)
            next_cur.wdata = pwdata[15:0];
        else if (wrAcc && paddr == LHP_APB_RING)
        begin
            next_cur.tx_ring_len_code = pwdata[LHP_TX_RING_LEN_CODE_MSB:LHP_TX_RING_LEN_CODE_LSB];
            next_cur.tx_ring_base     = pwdata[23:3];
        end
        case (cur.st)
            LHP_H_IDLE:
            begin
                // cmd bit0 read, bit1 pointer cycle; no select while granted
                if (wrAcc && paddr == LHP_APB_CMD && !link.bus_grant_in)
                begin
                    next_cur.rd     = pwdata[0];
                    next_cur.ptrCyc = pwdata[1];
                    next_cur.done   = 1'b0;
                    next_cur.st     = LHP_H_STRB;
                end
            end
            LHP_H_STRB:
            begin
                if (link.ready)
                begin
                    next_cur.rdata = link.devData;
                    next_cur.done  = 1'b1;
                    next_cur.st    = LHP_H_DONE;
                end
            end
            LHP_H_DONE:
            begin
                if (!link.ready)
                    next_cur.st = LHP_H_IDLE;
            end
            default: next_cur.st = LHP_H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // link drive; stop and config rewrite are software's duty
    assign link.chipSel_n     = (cur.st == LHP_H_IDLE);
    assign link.data_strobe_n = (cur.st != LHP_H_STRB);
    assign link.readNotWrite  = cur.rd;
    assign link.ptrSel        = cur.ptrCyc;
    assign link.hostData      = cur.wdata;

    // apb read mux, zero wait
    always_comb
    begin
        if (paddr == LHP_APB_RDATA)
            prdata = {16'h0000, cur.rdata};
        else if (paddr == LHP_APB_WDATA)
            prdata = {16'h0000, cur.wdata};
        else if (paddr == LHP_APB_STATUS)
            prdata = {30'h00000000, cur.done, cur.st != LHP_H_IDLE};
        else if (paddr == LHP_APB_RING)
            prdata = txRingPtr;
        else
            prdata = 32'h00000000;
    end
    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign txRingPtr = {cur.tx_ring_len_code, 5'h00, cur.tx_ring_base,
                        LHP_RING_ALIGN};
endmodule // lhp_host_end

// ===== sim/lhp_link_chk.sv
// concurrent checks on the link between host end and slave port
`timescale 1ns/1ps
module lhp_link_chk
    import lhp_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // link signals
    input wire logic        chipSel_n,
    input wire logic        data_strobe_n,
    input wire logic        readNotWrite,
    input wire logic        ptrSel,
    input wire logic [15:0] hostData,
    input wire logic [15:0] devData,
    input wire logic        ready,
    input wire logic        bus_grant_in
);
    logic [1:0] ptrTrack;
    logic       freshCtl;
    logic       isLong;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // mirror of the pointer; register 0 counts as fresh until written
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ptrTrack <= 2'h0;
            freshCtl <= 1'b1;
        end
        else if (ready && !data_strobe_n && !readNotWrite)
        begin
            if (ptrSel)
                ptrTrack <= hostData[1:0];
            else if (ptrTrack == LHP_SEL_CTL0)
                freshCtl <= 1'b0;
        end
    end
    // address registers are the slow class
    assign isLong = !ptrSel && ptrTrack inside {LHP_SEL_ADRL, LHP_SEL_ADRH};
    property p_rise_sel;
        $rose(ready) |-> !data_strobe_n && !chipSel_n;
    endproperty
    a_rise_sel: assert property (p_rise_sel) else $error("ready w/o request");
    property p_stand;
        ready && !data_strobe_n |=> ready;
    endproperty
    a_stand: assert property (p_stand) else $error("ready dropped early");
    property p_drop;
        $rose(data_strobe_n) |=> !ready;
    endproperty
    a_drop: assert property (p_drop) else $error("ready held too long");
    property p_short;
        $fell(data_strobe_n) && !isLong |-> ##[1:5] ready;
    endproperty
    a_short: assert property (p_short) else $error("short ack late");
    property p_long;
        $fell(data_strobe_n) && isLong |-> !ready[*4] ##[1:6] ready;
    endproperty
    a_long: assert property (p_long) else $error("long ack timing");
    property p_ctl_rst;
        ready && readNotWrite && !ptrSel && ptrTrack == LHP_SEL_CTL0
            && freshCtl |-> devData == LHP_CTL0_RST;
    endproperty
    a_ctl_rst: assert property (p_ctl_rst) else $error("ctl0 reset value");
    property p_ptr_back;
        ready && readNotWrite && ptrSel |-> devData[1:0] == ptrTrack;
    endproperty
    a_ptr_back: assert property (p_ptr_back) else $error("pointer lost");
    property p_no_grant;
        $fell(chipSel_n) |-> !$past(bus_grant_in);
    endproperty
    a_no_grant: assert property (p_no_grant) else $error("select in grant");
    // main transfer kinds
    c_long: cover property ($rose(ready) && isLong);
    c_ptr_rd: cover property (ready && readNotWrite && ptrSel);
    c_wr: cover property ($rose(ready) && !ptrSel && !readNotWrite);
endmodule // lhp_link_chk

// ===== sim/lhp_host_slave_port_tb_top.sv
// bench: host end and slave port face each other over the link
`timescale 1ns/1ps
module lhp_host_slave_port_tb_top;
    import lhp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic memNeed = 1'b0;
    logic dmaByte = 1'b1;
    logic [15:0] fifoWord = 16'h12C4;
    logic latchPhase = 1'b1;
    logic extFree = 1'b1;
    logic sawSlave = 1'b0;
    logic pready, chainReqIn, chainReqOut, chainReqOe, busRequest, byteSel;
    logic chain_grant_out_n, addrLatch, running, slaveMode, pslverr;
    logic [1:0] byte_mask_n;
    logic [15:0] memWord;
    logic [31:0] prdata, initBlockAddr, txRingPtr, rd;
    int nFail = 0;
    int nTests = 0;
    int cyc = 0;
    lhp_link_if lhp_link_if_inst ();
    // open-drain request wire: low if either party pulls it
    assign chainReqIn = (chainReqOe ? chainReqOut : 1'b1) & extFree;
    // slave mode must show up at least once during link accesses
    always @(posedge clk)
        if (slaveMode === 1'b1)
            sawSlave <= 1'b1;
    always #25 clk = ~clk;
    lhp_slave_port lhp_slave_port_inst (.clk(clk), .sys_rst(sys_rst),
        .link(lhp_link_if_inst), .memNeed(memNeed), .dmaAddrLsb(1'b0),
        .dmaByte(dmaByte), .dmaUpper(1'b0), .fifoWord(fifoWord),
        .latchPhase(latchPhase), .chainReqIn(chainReqIn),
        .chainReqOut(chainReqOut), .chainReqOe(chainReqOe),
        .byte_mask_n(byte_mask_n), .busRequest(busRequest),
        .byteSel(byteSel), .chain_grant_out_n(chain_grant_out_n),
        .addrLatch(addrLatch), .memWord(memWord), .running(running),
        .initBlockAddr(initBlockAddr), .slaveMode(slaveMode));
    lhp_host_end lhp_host_end_inst (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .link(lhp_link_if_inst), .txRingPtr(txRingPtr));
    lhp_link_chk lhp_link_chk_inst (.clk(clk), .sys_rst(sys_rst),
        .chipSel_n(lhp_link_if_inst.chipSel_n),
        .data_strobe_n(lhp_link_if_inst.data_strobe_n),
        .readNotWrite(lhp_link_if_inst.readNotWrite),
        .ptrSel(lhp_link_if_inst.ptrSel),
        .hostData(lhp_link_if_inst.hostData),
        .devData(lhp_link_if_inst.devData), .ready(lhp_link_if_inst.ready),
        .bus_grant_in(lhp_link_if_inst.bus_grant_in));
    task automatic chk(input string nm, input logic [31:0] e, g);
        nTests++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            nFail++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one link cycle: data, wait not busy, command, wait done, result
    task automatic acc(input logic r, p, input logic [15:0] d,
                       output logic [31:0] q);
        logic [31:0] s;
        apb(1'b1, LHP_APB_WDATA, {16'h0, d}, q);
        // status: bit0 busy, bit1 done; done stays set until next command
        s = 32'h1;
        while (s[0])
            apb(1'b0, LHP_APB_STATUS, 32'h0, s);
        apb(1'b1, LHP_APB_CMD, {30'h0, p, r}, q);
        s = 32'h1;
        while (s[0] || !s[1])
            apb(1'b0, LHP_APB_STATUS, 32'h0, s);
        apb(1'b0, LHP_APB_RDATA, 32'h0, q);
        q = {16'h0, q[15:0]};
    endtask
    task automatic wreg(input logic [1:0] sel, input logic [15:0] d);
        logic [31:0] q;
        acc(1'b0, 1'b1, {14'h0, sel}, q);
        acc(1'b0, 1'b0, d, q);
    endtask
    task automatic rreg(input logic [1:0] sel, output logic [31:0] q);
        acc(1'b0, 1'b1, {14'h0, sel}, q);
        acc(1'b1, 1'b0, 16'h0, q);
    endtask
    // pin stimulus, then let registered outputs settle
    task automatic pins(input logic g, n, f);
        @(posedge clk);
        lhp_link_if_inst.bus_grant_in <= g;
        memNeed <= n;
        extFree <= f;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // hang guard, well above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            nFail++;
            close_out();
        end
    end
    initial
    begin
        lhp_link_if_inst.bus_grant_in = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rreg(LHP_SEL_CTL0, rd);
        chk("ctl0", {16'h0, LHP_CTL0_RST}, rd);
        chk("running", 32'h0, {31'h0, running});
        acc(1'b1, 1'b1, 16'h0, rd);
        chk("pointer", 32'h0, {30'h0, rd[1:0]});
        rreg(LHP_SEL_CFG, rd);
        chk("cfg", 32'h0, rd);
        wreg(LHP_SEL_ADRL, 16'h1234);
        wreg(LHP_SEL_ADRH, 16'h00AB);
        chk("initaddr", 32'h00AB1234, initBlockAddr);
        acc(1'b1, 1'b0, 16'h0, rd);
        chk("reg2 again", 32'h00AB, rd);
        rreg(LHP_SEL_ADRL, rd);
        chk("reg1", 32'h1234, rd);
        wreg(LHP_SEL_CFG, 16'h0007);
        wreg(LHP_SEL_CTL0, 16'h0002);
        chk("running", 32'h1, {31'h0, running});
        rreg(LHP_SEL_CTL0, rd);
        chk("ctl0 run", 32'h2, {30'h0, rd[3:2]});
        wreg(LHP_SEL_ADRL, 16'hFFFF);
        chk("initaddr", 32'h00AB1234, initBlockAddr);
        pins(1'b1, 1'b0, 1'b1);
        chk("grant pass", 32'h0, {31'h0, chain_grant_out_n});
        chk("byteSel", 32'h1, {31'h0, byteSel});
        chk("latch", 32'h1, {31'h0, addrLatch});
        chk("swap", 32'hC412, {16'h0, memWord});
        pins(1'b0, 1'b1, 1'b0);
        chk("req busy", 32'h0, {31'h0, chainReqOe});
        pins(1'b0, 1'b1, 1'b1);
        chk("req free", 32'h1, {31'h0, chainReqOe});
        pins(1'b1, 1'b1, 1'b1);
        chk("grant kept", 32'h1, {31'h0, chain_grant_out_n});
        pins(1'b0, 1'b0, 1'b1);
        wreg(LHP_SEL_CTL0, 16'h0004);
        chk("running", 32'h0, {31'h0, running});
        rreg(LHP_SEL_CFG, rd);
        chk("cfg stop", 32'h0, rd);
        wreg(LHP_SEL_CFG, 16'h0000);
        wreg(LHP_SEL_CTL0, 16'h0002);
        pins(1'b1, 1'b1, 1'b1);
        chk("busreq", 32'h1, {31'h0, busRequest});
        chk("mask", 32'h2, {30'h0, byte_mask_n});
        chk("latch", 32'h0, {31'h0, addrLatch});
        chk("noswap", 32'h12C4, {16'h0, memWord});
        pins(1'b0, 1'b0, 1'b1);
        apb(1'b1, LHP_APB_RING, 32'hBFABCDEF, rd);
        // read back first so the register has surely taken the write
        apb(1'b0, LHP_APB_RING, 32'h0, rd);
        chk("ring rd", 32'hA0ABCDE8, rd);
        chk("ring", 32'hA0ABCDE8, txRingPtr);
        apb(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("pslverr", 32'h0, {31'h0, pslverr});
        chk("slave seen", 32'h1, {31'h0, sawSlave});
        chk("slave idle", 32'h0, {31'h0, slaveMode});
        close_out();
    end
endmodule // lhp_host_slave_port_tb_top
